// File: adcsp_host.sv
/*
  Host end: serial master that makes the link clock, frames each
  conversion by its chip-select pattern, gathers the result and
  buffers it for the user.
  Assumes the converter end answers within five block clocks of a
  link clock edge.
*/
// Contract
// RL1: convert-start fall holds input, drives data low
// RL2: normal conversion takes sixteen link clocks
// RL3: low at 16th fall releases data
// RL4: rise between 14th and 16th keeps driving
// RL5: data changes only on link clock rise
// RL6: three zeros, twelve bits MSB first, zero
// RL7: host is master, clock at most 28.8 MHz
// RL8: byte host gathers two eight-bit transfers
// RL9: host captures on the proper clock edge
// RL10: reference off only in full power-down
// RL11: wait 2 ms for reference settling
// RL12: convert-start idles high during power-down
// RL13: eight-clock frame enters power-down
// RL14: continuous: one-clock high pulse during last bit
// RL15: single: low for the whole frame
// RL16: patterns 0001 continuous, 00FF power-down
// RL17: fourth rise presents the result MSB
// RL18: early rise after third enters partial power-down
// RL19: full power-down only from partial power-down
// RL20: exit needs fourteen clocks with convert-start low
`timescale 1ns/1ps
`default_nettype none
`include "adcsp_defines.svh"
module adcsp_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 2
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [CW-1:0] cnt_r;

  wire do_in = in_valid & in_ready;
  wire do_out = out_valid & out_ready;
  wire [AW-1:0] wr_inc = (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + AW'(1);
  wire [AW-1:0] rd_inc = (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + AW'(1);

  always_ff @(posedge clock)
  begin
    if (do_in)
      mem_r[wr_r] <= in_data;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (do_in)
        wr_r <= wr_inc;
      if (do_out)
        rd_r <= rd_inc;
      cnt_r <= cnt_r + CW'(do_in) - CW'(do_out);
    end
  end

  assign in_ready = cnt_r != CW'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem_r[rd_r];
  assign count = cnt_r;
endmodule : adcsp_fifo

module adcsp_host #(
  parameter int unsigned SETTLE_CYC = `ADCSP_SETTLE_CYC
) (
  input wire logic clock,
  input wire logic rst,
  adcsp_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire adcsp_pkg::adcsp_op_t cmd_op,
  output logic res_valid,
  input wire logic res_ready,
  output logic [`ADCSP_RES_BITS-1:0] res_data,
  output var adcsp_pkg::adcsp_pwr_t pd_state,
  output logic ref_settled
);
  import adcsp_pkg::*;

  adcsp_hst_t st_r;
  adcsp_hst_t st_nxt;
  adcsp_op_t op_r;
  adcsp_op_t op_nxt;
  adcsp_pwr_t pwr_r;
  adcsp_pwr_t pwr_nxt;
  logic [3:0] ph_r;
  logic [3:0] ph_nxt;
  logic sclk_r;
  logic sclk_nxt;
  logic cs_r;
  logic cs_nxt;
  logic [4:0] bit_r;
  logic [4:0] bit_nxt;
  logic [4:0] len_r;
  logic [4:0] len_nxt;
  logic [15:0] pat_r;
  logic [15:0] pat_nxt;
  logic [7:0] byte_r;
  logic [7:0] byte_nxt;
  logic [7:0] hi_r;
  logic [7:0] hi_nxt;
  logic [31:0] settle_r;
  logic [31:0] settle_nxt;
  logic [1:0] dsync_r;
  logic [1:0] fifo_cnt;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      dsync_r <= 2'h3;
    else
      dsync_r <= {dsync_r[0], link.dout};
  end

  wire ph_rise = (st_r == ST_RUN) && (ph_r == `ADCSP_PH_RISE);
  wire ph_fall = (st_r == ST_RUN) && (ph_r == `ADCSP_PH_FALL);
  wire [4:0] bit_inc = bit_r + 5'h01;
  wire frame_end = ph_fall && (bit_inc == len_r);
  wire [7:0] byte_in = {byte_r[6:0], dsync_r[1]};
  wire [15:0] frame_word = {hi_r, byte_in};
  wire data_cmd = (cmd_op == OP_SINGLE) || (cmd_op == OP_CONT);
  wire data_run = (op_r == OP_SINGLE) || (op_r == OP_CONT);
  wire push = frame_end & data_run;
  wire [1:0] fill = fifo_cnt + {1'b0, push};
  wire room = fill < 2'h2;
  wire settled = (settle_r == 32'h0000_0000) && (pwr_r != PWR_FULL);
  wire op_ok = ~data_cmd | (settled & room); // RL11
  wire cont_go = frame_end && (op_r == OP_CONT) && (cmd_op == OP_CONT); // RL4
  wire accept = cmd_valid & cmd_ready;
  wire [15:0] pat_sel = (cmd_op == OP_CONT) ? `ADCSP_PAT_CONT :
                        (cmd_op == OP_PDOWN) ? `ADCSP_PAT_PDOWN : `ADCSP_PAT_SINGLE; // RL16
  wire [4:0] len_sel = (cmd_op == OP_PDOWN) ? `ADCSP_PD_FRAME_BITS : `ADCSP_FRAME_BITS; // RL13
  wire [3:0] pat_idx = 4'(5'h0F - bit_inc);

  assign cmd_ready = op_ok & ((st_r == ST_IDLE) | cont_go);

  always_comb
  begin
    st_nxt = st_r;
    op_nxt = op_r;
    pwr_nxt = pwr_r;
    ph_nxt = (st_r == ST_RUN) ? ph_r + 4'h1 : 4'h0;
    sclk_nxt = sclk_r;
    cs_nxt = cs_r;
    bit_nxt = bit_r;
    len_nxt = len_r;
    pat_nxt = pat_r;
    byte_nxt = byte_r;
    hi_nxt = hi_r;
    settle_nxt = (settle_r != 32'h0000_0000) ? settle_r - 32'h0000_0001 : settle_r;
    // clock idles low; data is valid after the rise, taken at the fall
    if (ph_rise)
      sclk_nxt = 1'b1; // RL7
    if (ph_fall)
    begin
      sclk_nxt = 1'b0;
      bit_nxt = bit_inc;
      byte_nxt = byte_in; // RL9
      if (bit_inc == `ADCSP_BYTE_BITS)
        hi_nxt = byte_in; // RL8
      if (bit_inc < len_r)
        cs_nxt = pat_r[pat_idx]; // RL14 RL15
    end
    if (frame_end)
    begin
      st_nxt = ST_IDLE;
      cs_nxt = 1'b1; // RL12
      if (op_r == OP_PDOWN)
        pwr_nxt = (pwr_r == PWR_NORMAL) ? PWR_PARTIAL : PWR_FULL; // RL18 RL19
      else
      begin
        pwr_nxt = PWR_NORMAL; // RL20
        if (pwr_r == PWR_FULL)
          settle_nxt = SETTLE_CYC; // RL11
      end
    end
    if (accept)
    begin
      st_nxt = ST_RUN;
      op_nxt = cmd_op;
      ph_nxt = 4'h0;
      bit_nxt = 5'h00; // RL2
      cs_nxt = 1'b0;
      pat_nxt = pat_sel;
      len_nxt = len_sel;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_r <= ST_IDLE;
      op_r <= OP_SINGLE;
      pwr_r <= PWR_NORMAL;
      ph_r <= 4'h0;
      sclk_r <= 1'b0;
      cs_r <= 1'b1;
      bit_r <= 5'h00;
      len_r <= `ADCSP_FRAME_BITS;
      pat_r <= `ADCSP_PAT_SINGLE;
      byte_r <= 8'h00;
      hi_r <= 8'h00;
      settle_r <= SETTLE_CYC; // RL11
    end
    else
    begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      pwr_r <= pwr_nxt;
      ph_r <= ph_nxt;
      sclk_r <= sclk_nxt;
      cs_r <= cs_nxt;
      bit_r <= bit_nxt;
      len_r <= len_nxt;
      pat_r <= pat_nxt;
      byte_r <= byte_nxt;
      hi_r <= hi_nxt;
      settle_r <= settle_nxt;
    end
  end

  adcsp_fifo #(
    .WIDTH(`ADCSP_RES_BITS),
    .DEPTH(2)
  ) i_adcsp_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(push),
    .in_ready(),
    .in_data(frame_word[12:1]),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data),
    .count(fifo_cnt)
  );

  assign link.sclk = sclk_r;
  assign link.convert_start = cs_r;
  assign pd_state = pwr_r;
  assign ref_settled = settled;
endmodule : adcsp_host
`default_nettype wire

// File: adcsp_defines.svh
/*
  Constants for the converter serial port: frame layout, edge counts,
  chip-select patterns and host timing.
  Assumes a 25 MHz block clock on both ends.
*/
`ifndef ADCSP_DEFINES_SVH
`define ADCSP_DEFINES_SVH

`define ADCSP_RES_BITS 12
`define ADCSP_FRAME_BITS 5'h10
`define ADCSP_PD_FRAME_BITS 5'h08
`define ADCSP_BYTE_BITS 5'h08
`define ADCSP_PD_AFTER_RISE 5'h03
`define ADCSP_KEEP_RISE 5'h0E
`define ADCSP_LAST_FALL 5'h10
`define ADCSP_PAT_SINGLE 16'h0000
`define ADCSP_PAT_CONT 16'h0001
`define ADCSP_PAT_PDOWN 16'h00FF
`define ADCSP_CLK_KHZ 25000
`define ADCSP_SCLK_MAX_KHZ 28800
`define ADCSP_SCLK_HALF 8
`define ADCSP_PH_RISE 4'h7
`define ADCSP_PH_FALL 4'hF
`define ADCSP_SETTLE_MS 2
`define ADCSP_SETTLE_CYC (`ADCSP_SETTLE_MS * `ADCSP_CLK_KHZ)

`endif

// File: adcsp_pkg.sv
/*
  Types for the converter serial port; only the power state is shared by both ends.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package adcsp_pkg;
  typedef enum logic [1:0] {PWR_NORMAL, PWR_PARTIAL, PWR_FULL} adcsp_pwr_t;
  typedef enum logic [1:0] {OP_SINGLE, OP_CONT, OP_PDOWN, OP_WAKE} adcsp_op_t;
  typedef enum logic {ST_IDLE, ST_RUN} adcsp_hst_t;
endpackage : adcsp_pkg

// File: adcsp_if.sv
/*
  Three-wire link between host and converter.
  Assumes the data line idles high when the converter does not drive it.
*/
`timescale 1ns/1ps
`default_nettype none
interface adcsp_if;
  logic sclk;
  logic convert_start;
  logic dout_o;
  logic dout_oe_n;
  logic dout;
  // resolved line level, pulled high when released
  assign dout = dout_oe_n ? 1'b1 : dout_o;
  modport dev (input sclk, input convert_start, output dout_o, output dout_oe_n);
  modport host (output sclk, output convert_start, input dout);
endinterface : adcsp_if
`default_nettype wire

// File: adcsp_dev.sv
/*
  Converter end: samples the link pins, runs the conversion frame,
  shifts the result out and tracks the power-down state.
  Assumes link pins are asynchronous and the link clock is slow enough
  for the block clock to see every edge.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adcsp_defines.svh"
module adcsp_dev (
  input wire logic clock,
  input wire logic rst,
  adcsp_if.dev link,
  input wire logic [`ADCSP_RES_BITS-1:0] sample,
  output var adcsp_pkg::adcsp_pwr_t pwr_state,
  output logic ref_on,
  output logic track_hold
);
  import adcsp_pkg::*;

  logic [1:0] sclk_s_r;
  logic [1:0] cs_s_r;
  logic sclk_d_r;
  logic cs_d_r;
  logic active_r;
  logic active_nxt;
  logic drive_r;
  logic drive_nxt;
  logic dout_r;
  logic dout_nxt;
  logic rel_r;
  logic rel_nxt;
  logic [4:0] rise_r;
  logic [4:0] rise_nxt;
  logic [4:0] fall_r;
  logic [4:0] fall_nxt;
  logic [`ADCSP_RES_BITS-1:0] word_r;
  logic [`ADCSP_RES_BITS-1:0] word_nxt;
  adcsp_pwr_t pwr_r;
  adcsp_pwr_t pwr_nxt;

  // two-stage pin synchronisers, then one delay stage for edges
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sclk_s_r <= 2'h0;
      cs_s_r <= 2'h3;
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end
    else
    begin
      sclk_s_r <= {sclk_s_r[0], link.sclk};
      cs_s_r <= {cs_s_r[0], link.convert_start};
      sclk_d_r <= sclk_s_r[1];
      cs_d_r <= cs_s_r[1];
    end
  end

  wire sclk_rise = sclk_s_r[1] & ~sclk_d_r;
  wire sclk_fall = ~sclk_s_r[1] & sclk_d_r;
  wire cs_fall = ~cs_s_r[1] & cs_d_r;
  wire cs_rise = cs_s_r[1] & ~cs_d_r;
  wire [4:0] rise_inc = (rise_r == 5'h1F) ? rise_r : rise_r + 5'h01;
  wire [4:0] fall_inc = (fall_r == 5'h1F) ? fall_r : fall_r + 5'h01;
  wire [15:0] frame_word = {3'h0, word_r, 1'b0};
  wire [3:0] bit_idx = 4'(`ADCSP_FRAME_BITS - rise_inc);
  wire in_frame_bit = rise_inc <= `ADCSP_FRAME_BITS;
  wire wake_win = rise_r >= `ADCSP_KEEP_RISE;
  // a rise at the 16th fall or later is a normal end, so the line is released
  wire keep_win = wake_win && (rise_r < `ADCSP_FRAME_BITS);
  wire pd_win = (rise_r > `ADCSP_PD_AFTER_RISE) && (rise_r < `ADCSP_KEEP_RISE);

  always_comb
  begin
    active_nxt = active_r;
    drive_nxt = drive_r;
    dout_nxt = dout_r;
    rel_nxt = rel_r;
    rise_nxt = rise_r;
    fall_nxt = fall_r;
    word_nxt = word_r;
    pwr_nxt = pwr_r;
    if (cs_fall)
    begin
      // hold the input, start converting, drive the line low
      active_nxt = 1'b1; // RL1
      drive_nxt = 1'b1; // RL1
      dout_nxt = 1'b0; // RL1
      word_nxt = sample; // RL1
      rel_nxt = 1'b0;
      rise_nxt = 5'h00;
      fall_nxt = 5'h00;
    end
    else if (active_r && cs_rise)
    begin
      active_nxt = 1'b0;
      if (wake_win)
        pwr_nxt = PWR_NORMAL; // RL20
      if (keep_win)
        drive_nxt = ~rel_r; // RL3 RL4
      else
      begin
        drive_nxt = 1'b0; // RL3
        if (pd_win)
          pwr_nxt = (pwr_r == PWR_NORMAL) ? PWR_PARTIAL : PWR_FULL; // RL18 RL19
      end
    end
    else if (active_r && sclk_rise)
    begin
      rise_nxt = rise_inc; // RL2
      if (rel_r)
        drive_nxt = 1'b0; // RL3
      else if (in_frame_bit)
        dout_nxt = frame_word[bit_idx]; // RL5 RL6 RL17
    end
    else if (active_r && sclk_fall)
    begin
      fall_nxt = fall_inc;
      if (fall_inc == `ADCSP_LAST_FALL)
        rel_nxt = 1'b1; // RL3
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      active_r <= 1'b0;
      drive_r <= 1'b0;
      dout_r <= 1'b0;
      rel_r <= 1'b0;
      rise_r <= 5'h00;
      fall_r <= 5'h00;
      word_r <= '0;
      pwr_r <= PWR_NORMAL;
    end
    else
    begin
      active_r <= active_nxt;
      drive_r <= drive_nxt;
      dout_r <= dout_nxt;
      rel_r <= rel_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
      word_r <= word_nxt;
      pwr_r <= pwr_nxt;
    end
  end

  assign link.dout_o = dout_r;
  assign link.dout_oe_n = ~drive_r;
  assign pwr_state = pwr_r;
  assign ref_on = pwr_r != PWR_FULL; // RL10
  assign track_hold = active_r & (rise_r < `ADCSP_KEEP_RISE);
endmodule : adcsp_dev
`default_nettype wire

// File: adcsp_props.sv
/*
  Link checker for the converter serial port, on the interface wires.
  Assumes both ends share one block clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none
module adcsp_props (
  input wire logic clock,
  input wire logic rst,
  input wire logic sclk,
  input wire logic convert_start,
  input wire logic dout_o,
  input wire logic dout_oe_n,
  input wire logic dout
);
  logic [4:0] rise_r;
  logic [4:0] fall_r;
  logic [3:0] since_r;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // link edges counted within a frame
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rise_r <= 5'h00;
      fall_r <= 5'h00;
    end
    else if ($fell(convert_start))
    begin
      rise_r <= 5'h00;
      fall_r <= 5'h00;
    end
    else
    begin
      if ($rose(sclk) && !convert_start)
        rise_r <= rise_r + 5'h01;
      if ($fell(sclk) && !convert_start)
        fall_r <= fall_r + 5'h01;
    end
  end
  // cycles since a link clock rise or frame start
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      since_r <= 4'h0;
    else if ($rose(sclk) || $fell(convert_start))
      since_r <= 4'h0;
    else if (since_r != 4'hF)
      since_r <= since_r + 4'h1;
  end
  property p_cs_fall_drive;
    $fell(convert_start) |-> ##[1:6] (!dout_oe_n && !dout_o);
  endproperty
  a_cs_fall_drive: assert property (p_cs_fall_drive) else $error("data not driven low");
  property p_data_on_rise;
    ($changed(dout_o) && !dout_oe_n) |-> since_r <= 4'h6;
  endproperty
  a_data_on_rise: assert property (p_data_on_rise) else $error("data moved off rise");
  property p_sclk_high;
    $rose(sclk) |-> sclk [*8] ##1 !sclk;
  endproperty
  a_sclk_high: assert property (p_sclk_high) else $error("link clock high time");
  property p_cs_on_fall;
    $rose(convert_start) |-> $fell(sclk);
  endproperty
  a_cs_on_fall: assert property (p_cs_on_fall) else $error("frame end off a fall");
  property p_single_release;
    ($rose(convert_start) && $fell(sclk) && fall_r == 5'h0F) |-> ##[1:6] dout_oe_n;
  endproperty
  a_single_release: assert property (p_single_release) else $error("no release");
  property p_cont_keep;
    ($rose(convert_start) && rise_r >= 5'h0E && rise_r < 5'h10) |-> !dout_oe_n [*8];
  endproperty
  a_cont_keep: assert property (p_cont_keep) else $error("data dropped");
  property p_pd_release;
    ($rose(convert_start) && rise_r > 5'h03 && rise_r < 5'h0E) |-> ##[1:6] dout_oe_n;
  endproperty
  a_pd_release: assert property (p_pd_release) else $error("no release on sleep");
  property p_lead_zero;
    (!convert_start && rise_r < 5'h04 && !dout_oe_n) |-> !dout;
  endproperty
  a_lead_zero: assert property (p_lead_zero) else $error("leading bit not zero");
endmodule : adcsp_props
`default_nettype wire

// File: adc_serial_conversion_port_tb.sv
/*
  Bench joining host and converter ends over the link.
  Assumes design files and checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adcsp_defines.svh"
module adc_serial_conversion_port_tb;
  import adcsp_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic res_ready = 1'b0;
  adcsp_op_t cmd_op = OP_SINGLE;
  logic [`ADCSP_RES_BITS-1:0] sample = 12'h000;
  logic cmd_ready, res_valid, ref_on, track_hold, ref_settled;
  logic [`ADCSP_RES_BITS-1:0] res_data;
  adcsp_pwr_t pwr_state;
  adcsp_pwr_t pd_state;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  adcsp_if link();
  adcsp_dev i_adcsp_dev (.clock(clock), .rst(rst), .link(link), .sample(sample),
    .pwr_state(pwr_state), .ref_on(ref_on), .track_hold(track_hold));
  adcsp_host #(.SETTLE_CYC(20)) i_adcsp_host (.clock(clock), .rst(rst), .link(link),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .res_valid(res_valid),
    .res_ready(res_ready), .res_data(res_data), .pd_state(pd_state),
    .ref_settled(ref_settled));
  adcsp_props i_adcsp_props (.clock(clock), .rst(rst), .sclk(link.sclk),
    .convert_start(link.convert_start), .dout_o(link.dout_o),
    .dout_oe_n(link.dout_oe_n), .dout(link.dout));
  always #20 clock = ~clock;
  task automatic print_verdict();
    if (errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  // hang guard
  always @(posedge clock)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      errors = errors + 1;
      print_verdict();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked = checked + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic send(input adcsp_op_t op);
    int n;
    n = 0;
    @(negedge clock);
    cmd_op = op;
    cmd_valid = 1'b1;
    #1;
    while (cmd_ready !== 1'b1 && n < 3000)
    begin
      @(negedge clock);
      #1;
      n++;
    end
    if (n >= 3000)
      errors = errors + 1;
    @(negedge clock);
    cmd_valid = 1'b0;
  endtask : send
  task automatic get_res(output logic [11:0] d);
    int n;
    n = 0;
    @(negedge clock);
    res_ready = 1'b1;
    while (res_valid !== 1'b1 && n < 3000)
    begin
      @(negedge clock);
      n++;
    end
    if (n >= 3000)
      errors = errors + 1;
    d = res_data;
    @(negedge clock);
    res_ready = 1'b0;
  endtask : get_res
  task automatic t_power();
    send(OP_PDOWN);
    repeat (150) @(negedge clock);
    check(16'(pwr_state), 16'(PWR_PARTIAL));
    check(16'(pd_state), 16'(PWR_PARTIAL));
    check(16'(link.dout), 16'h0001);
    check(16'(ref_on), 16'h0001);
    send(OP_PDOWN);
    repeat (150) @(negedge clock);
    check(16'(pwr_state), 16'(PWR_FULL));
    check(16'(pd_state), 16'(PWR_FULL));
    check(16'(ref_on), 16'h0000);
    check(16'(link.convert_start), 16'h0001);
    cmd_op = OP_SINGLE;
    #1;
    check(16'(cmd_ready), 16'h0000);
    send(OP_WAKE);
    check(16'(ref_settled), 16'h0000);
    repeat (320) @(negedge clock);
    check(16'(pwr_state), 16'(PWR_NORMAL));
    check(16'(pd_state), 16'(PWR_NORMAL));
    check(16'(ref_settled), 16'h0001);
  endtask : t_power
  task automatic t_single(input logic [11:0] s);
    logic [15:0] w;
    logic [11:0] d;
    @(negedge clock);
    sample = s;
    send(OP_SINGLE);
    w = 16'h0000;
    repeat (6) @(negedge clock);
    check(16'(track_hold), 16'h0001);
    check(16'(link.dout), 16'h0000);
    repeat (16)
    begin
      @(negedge link.sclk);
      w = {w[14:0], link.dout};
    end
    check(w, {3'b000, s, 1'b0});
    get_res(d);
    check(16'(d), 16'(s));
    repeat (8) @(negedge clock);
    check(16'(link.dout_oe_n), 16'h0001);
    check(16'(track_hold), 16'h0000);
  endtask : t_single
  task automatic t_cont();
    logic [11:0] d;
    int n;
    @(negedge clock);
    sample = 12'h3C6;
    send(OP_CONT);
    fork
      begin
        repeat (60) @(negedge clock);
        sample = 12'hC39;
        send(OP_CONT);
      end
      begin
        @(posedge link.convert_start);
        n = 0;
        @(negedge clock);
        while (link.convert_start === 1'b1 && n < 100)
        begin
          n++;
          @(negedge clock);
        end
      end
    join
    check(16'(n), 16'h0010);
    repeat (300) @(negedge clock);
    check(16'(link.dout_oe_n), 16'h0000);
    cmd_op = OP_SINGLE;
    #1;
    check(16'(cmd_ready), 16'h0000);
    get_res(d);
    check(16'(d), 16'h03C6);
    get_res(d);
    check(16'(d), 16'h0C39);
    check(16'(res_valid), 16'h0000);
  endtask : t_cont
  initial
  begin
    repeat (12) @(negedge clock);
    rst = 1'b0;
    t_power();
    t_single(12'hA5C);
    t_single(12'hFFF);
    t_single(12'h001);
    t_cont();
    print_verdict();
  end
endmodule : adc_serial_conversion_port_tb
`default_nettype wire
